/* File: rifp_asserts.sv */
// Checker for the link joining the supervisor and the controller.
// Assumes one clock and sees only the link signals as inputs.
`timescale 1ns/1ps
module rifp_asserts #(
  parameter int unsigned WARN_CYC = rifp_pkg::PARK_WARN_CYC
) (
  input wire logic clk,                 // Reference clock.
  input wire logic rstn,                // Reset, active low.
  input wire logic sys_reset_low,       // Reset to the controller.
  input wire logic fast_park_request_n, // Park request, active low.
  input wire logic host_irq_o,          // Interrupt value.
  input wire logic host_irq_oe          // Interrupt drive enable.
);
  logic [15:0] park_cnt;
  logic [15:0] next_park_cnt;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  // Counts the cycles that the park request has been held low.
  always_comb begin
    next_park_cnt = fast_park_request_n ? 16'h0000 : park_cnt + 16'h0001;
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      park_cnt <= 16'h0000;
    end else begin
      park_cnt <= next_park_cnt;
    end
  end
  property p_quiet;
    !sys_reset_low [*4] |-> !host_irq_oe && !host_irq_o;
  endproperty
  a_quiet: assert property (p_quiet) else $error("irq driven in reset");
  property p_start;
    $rose(sys_reset_low) |-> ##[2:4] host_irq_oe && host_irq_o;
  endproperty
  a_start: assert property (p_start) else $error("irq not driven high");
  property p_done_stays;
    host_irq_oe && !host_irq_o |=> !host_irq_o;
  endproperty
  a_done_stays: assert property (p_done_stays) else $error("irq rose");
  property p_oe_cause;
    $fell(host_irq_oe) |-> !$past(sys_reset_low, 2);
  endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("irq oe lost");
  property p_park_high;
    $rose(sys_reset_low) |-> fast_park_request_n;
  endproperty
  a_park_high: assert property (p_park_high) else $error("park at release");
  property p_hold;
    $fell(sys_reset_low) && !fast_park_request_n |-> park_cnt >= WARN_CYC;
  endproperty
  a_hold: assert property (p_hold) else $error("park hold too short");
  property p_rearm;
    $rose(fast_park_request_n) |-> !sys_reset_low;
  endproperty
  a_rearm: assert property (p_rearm) else $error("park lifted in run");
  property p_pair;
    host_irq_o |-> host_irq_oe;
  endproperty
  a_pair: assert property (p_pair) else $error("irq value undriven");
  cover property ($rose(sys_reset_low));
  cover property (host_irq_oe && $fell(host_irq_o));
  cover property ($fell(fast_park_request_n));
endmodule

/* File: rifp_controller.sv */
// Controller end: reset-time safe states, start-up sequencing, host
// interrupt signalling and filtered fast park handling.
// Assumes the reset pin and park pin are asynchronous to clk.
`timescale 1ns/1ps

// Summary of operation
// R1: Supervisor holds reset until supplies stable.
// R2: In reset, outputs inactive, bidirectionals input.
// R3: In reset, illumination and flash outputs tristated.
// R4: Supervisor releases reset after stable clock.
// R5: After release, wait PLL lock, load flash.
// R6: After release, all pins become active.
// R7: Drive host interrupt high during initialization.
// R8: Drive host interrupt low when done.
// R9: Host waits for interrupt low before commands.
// R10: Park warning at least 40 us early.
// R11: Park request parks the mirror array.
// R12: Clock and reset kept 40 us after park.
// R13: Park input deglitched for 150 ns.
// R14: Test pins captured at reset release.
// R15: Reset release and park synchronised first.
module rifp_controller #(
  parameter int unsigned FILTER_CYC = rifp_pkg::PARK_FILTER_CYC
) (
  input wire logic clk,                 // Reference clock.
  input wire logic rstn,                // Power-on reset, active low.
  rifp_if.dev link,                     // Reset, park and interrupt.
  input wire logic pll_locked,          // PLL lock indication.
  input wire logic flash_load_done,     // Configuration load finished.
  input wire logic park_done,           // Mirror park finished.
  input wire logic [7:0] test_in,       // Test point pin levels.
  output logic [7:0] test_cfg,          // Captured test configuration.
  output logic [7:0] test_oe,           // Test point output enables.
  output logic flash_load_start,        // Start configuration load.
  output logic park_start,              // Start mirror park pulse.
  output logic parked,                  // Park has completed.
  output logic illum_select_0,          // Illumination select 0.
  output logic illum_select_0_oe,       // Its output enable.
  output logic illum_select_1,          // Illumination select 1.
  output logic illum_select_1_oe,       // Its output enable.
  output logic flash_serial_clock_oe,   // Flash clock output enable.
  output logic flash_serial_out_oe,     // Flash data output enable.
  output logic flash_chip_select_oe,    // Flash select output enable.
  output logic io_active                // Normal pin operation.
);
  import rifp_pkg::*;

  initial begin
    if (FILTER_CYC < 1 || FILTER_CYC > 255)
      $error("FILTER_CYC out of range");
  end

  typedef enum logic [2:0] {
    RIFP_RESET,
    RIFP_WAIT_LOCK,
    RIFP_LOAD,
    RIFP_RUN,
    RIFP_PARKING,
    RIFP_PARKED
  } rifp_state_type;

  // ----------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------
  logic rst_s1;
  logic rst_s2;
  logic park_s1;
  logic park_s2;
  logic [7:0] test_s1;
  logic [7:0] test_s2;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
      park_s1 <= 1'b1;
      park_s2 <= 1'b1;
      test_s1 <= TEST_DEFAULT;
      test_s2 <= TEST_DEFAULT;
    end else begin
      rst_s1 <= link.sys_reset_low;           // see R15
      rst_s2 <= rst_s1;
      park_s1 <= link.fast_park_request_n;    // see R15
      park_s2 <= park_s1;
      test_s1 <= test_in;
      test_s2 <= test_s1;
    end
  end

  // ----------------------------------------------------------------
  // Park deglitch filter
  // ----------------------------------------------------------------
  logic park_filt;
  logic next_park_filt;
  logic [7:0] flt_cnt;
  logic [7:0] next_flt_cnt;

  always_comb begin
    next_park_filt = park_filt;
    next_flt_cnt = 8'h00;
    // A new level must hold longer than the glitch window.  see R13
    if (park_s2 != park_filt) begin
      next_flt_cnt = flt_cnt + 8'h01;
      if (flt_cnt >= FILTER_CYC[7:0]) begin
        next_park_filt = park_s2;
        next_flt_cnt = 8'h00;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      park_filt <= 1'b1;
      flt_cnt <= 8'h00;
    end else begin
      park_filt <= next_park_filt;
      flt_cnt <= next_flt_cnt;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  rifp_state_type state;
  rifp_state_type next_state;
  logic next_load_start;
  logic next_park_start;
  logic [7:0] next_test_cfg;

  always_comb begin
    next_state = state;
    next_load_start = 1'b0;
    next_park_start = 1'b0;
    next_test_cfg = test_cfg;
    if (!rst_s2) begin
      next_state = RIFP_RESET;
    end else begin
      unique case (state)
        RIFP_RESET: begin
          next_test_cfg = test_s2;            // see R14
          next_state = RIFP_WAIT_LOCK;        // see R5
        end
        RIFP_WAIT_LOCK: begin
          if (pll_locked) begin
            next_load_start = 1'b1;           // see R5
            next_state = RIFP_LOAD;
          end
        end
        RIFP_LOAD: begin
          if (flash_load_done) next_state = RIFP_RUN;
        end
        RIFP_RUN: begin
          if (!park_filt) begin
            next_park_start = 1'b1;           // see R11
            next_state = RIFP_PARKING;
          end
        end
        RIFP_PARKING: begin
          if (park_done) next_state = RIFP_PARKED;
        end
        RIFP_PARKED: begin
          next_state = RIFP_PARKED;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registered pin controls
  // ----------------------------------------------------------------
  logic next_active;
  logic next_irq;
  logic next_irq_oe;
  logic next_parked;
  logic [7:0] next_test_oe;
  logic parked_r;
  logic [7:0] test_oe_r;

  always_comb begin
    // Safe states while reset; active from release.  see R2 see R6
    next_active = rst_s2 && next_state != RIFP_RESET;
    // High while initializing, low once done.  see R7 see R8
    next_irq_oe = next_active;
    next_irq = next_state == RIFP_WAIT_LOCK || next_state == RIFP_LOAD;
    next_parked = next_state == RIFP_PARKED;
    // Default configuration keeps test points undriven.  see R14
    next_test_oe = (next_active && next_test_cfg != TEST_DEFAULT) ?
                   8'hff : 8'h00;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= RIFP_RESET;
      test_cfg <= TEST_DEFAULT;
      flash_load_start <= 1'b0;
      park_start <= 1'b0;
      io_active <= 1'b0;
      link.host_irq_o <= 1'b0;
      link.host_irq_oe <= 1'b0;
      parked_r <= 1'b0;
      test_oe_r <= 8'h00;
    end else begin
      state <= next_state;
      test_cfg <= next_test_cfg;
      flash_load_start <= next_load_start;
      park_start <= next_park_start;
      io_active <= next_active;
      link.host_irq_o <= next_irq;
      link.host_irq_oe <= next_irq_oe;
      parked_r <= next_parked;
      test_oe_r <= next_test_oe;
    end
  end

  assign parked = parked_r;
  assign test_oe = test_oe_r;
  assign illum_select_0 = 1'b0;
  assign illum_select_1 = 1'b0;
  // Undriven in reset rather than driven inactive.
  assign illum_select_0_oe = io_active;      // see R3
  assign illum_select_1_oe = io_active;      // see R3
  assign flash_serial_clock_oe = io_active;  // see R3
  assign flash_serial_out_oe = io_active;    // see R3
  assign flash_chip_select_oe = io_active;   // see R3
endmodule

/* File: rifp_if.sv */
// Interface joining the controller end and the supervisor/host end.
// The testbench resolves the host interrupt wire from its enable.
`timescale 1ns/1ps
interface rifp_if;
  logic sys_reset_low;
  logic fast_park_request_n;
  logic host_irq_o;
  logic host_irq_oe;

  modport dev (
    input sys_reset_low,
    input fast_park_request_n,
    output host_irq_o,
    output host_irq_oe
  );

  modport sup (
    output sys_reset_low,
    output fast_park_request_n,
    input host_irq_o,
    input host_irq_oe
  );
endinterface

/* File: rifp_pkg.sv */
// Package for the reset, initialization and fast park controller.
// Assumes a single 40 MHz reference clock shared by both ends.
package rifp_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_PS = 25000;
  localparam int unsigned PARK_FILTER_NS = 150;
  localparam int unsigned PARK_WARN_US = 40;
  // Glitch window rounds up to whole cycles.
  localparam int unsigned PARK_FILTER_CYC =
      (PARK_FILTER_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // Warning lead time rounds up (a least time).
  localparam int unsigned PARK_WARN_CYC =
      (PARK_WARN_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // ----------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------
  localparam int unsigned TEST_W = 8;
  localparam logic [TEST_W-1:0] TEST_DEFAULT = 8'h00;

  typedef enum logic [1:0] {
    RIFP_INIT_PROG,
    RIFP_INIT_DONE
  } rifp_irq_type;

endpackage

/* File: rifp_supervisor.sv */
// Supervisor and host end: drives reset and fast park, watches the
// host interrupt wire. Assumes the interrupt line has a pull-up.
`timescale 1ns/1ps
module rifp_supervisor #(
  parameter int unsigned WARN_CYC = rifp_pkg::PARK_WARN_CYC
) (
  input wire logic clk,             // Reference clock.
  input wire logic rstn,            // Asynchronous reset, active low.
  rifp_if.sup link,                 // Link to the controller.
  input wire logic power_good,      // Supplies and clocks are stable.
  input wire logic power_failing,   // Supplies about to drop.
  output logic host_may_command,    // Host may start its commands.
  output logic park_hold_done       // Park lead time has passed.
);
  import rifp_pkg::*;

  initial begin
    if (WARN_CYC < 1) $error("WARN_CYC must be at least one");
  end

  logic rst_out;
  logic next_rst_out;
  logic park_n;
  logic next_park_n;
  logic may_cmd;
  logic next_may_cmd;
  logic hold_done;
  logic next_hold_done;
  logic [31:0] hold_cnt;
  logic [31:0] next_hold_cnt;
  logic irq_wire;
  logic irq_s1;
  logic irq_s2;

  // Pull-up when nobody drives the line.
  assign irq_wire = link.host_irq_oe ? link.host_irq_o : 1'b1;

  // ----------------------------------------------------------------
  // Sequencing
  // ----------------------------------------------------------------
  always_comb begin
    next_rst_out = rst_out;
    next_park_n = park_n;
    next_may_cmd = may_cmd;
    next_hold_done = hold_done;
    next_hold_cnt = hold_cnt;
    if (!rst_out) begin
      next_may_cmd = 1'b0;
      // Release only when stable and park is high.  see R1 see R4
      if (power_good && park_n) next_rst_out = 1'b1;
      if (!power_failing) next_park_n = 1'b1;
    end else begin
      if (!irq_s2) next_may_cmd = 1'b1;     // see R9
      if (power_failing && park_n) begin
        next_park_n = 1'b0;                 // see R10
        next_hold_cnt = 32'h0;
        next_hold_done = 1'b0;
      end else if (!park_n && !hold_done) begin
        // Reset stays released through the park window.  see R12
        next_hold_cnt = hold_cnt + 32'h1;
        if (hold_cnt + 32'h1 >= WARN_CYC) next_hold_done = 1'b1;
      end else if (!park_n && hold_done) begin
        next_rst_out = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_out <= 1'b0;
      park_n <= 1'b1;
      may_cmd <= 1'b0;
      hold_done <= 1'b0;
      hold_cnt <= 32'h0;
      irq_s1 <= 1'b1;
      irq_s2 <= 1'b1;
    end else begin
      rst_out <= next_rst_out;
      park_n <= next_park_n;
      may_cmd <= next_may_cmd;
      hold_done <= next_hold_done;
      hold_cnt <= next_hold_cnt;
      irq_s1 <= irq_wire;
      irq_s2 <= irq_s1;
    end
  end

  assign link.sys_reset_low = rst_out;
  assign link.fast_park_request_n = park_n;
  assign host_may_command = may_cmd;
  assign park_hold_done = hold_done;
endmodule

/* File: rifp_tb.sv */
// Testbench: supervisor and controller joined by the link interface.
// Assumes a pull-up on the interrupt wire and one 40 MHz clock.
`timescale 1ns/1ps
module rifp_tb;
  import rifp_pkg::*;
  localparam int unsigned FCYC = 6;
  localparam int unsigned WCYC = 20;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic power_good = 1'b0;
  logic power_failing = 1'b0;
  logic pll_locked = 1'b0;
  logic flash_load_done = 1'b0;
  logic park_done = 1'b0;
  logic [7:0] test_in = 8'h00;
  logic [7:0] test_cfg, test_oe;
  logic flash_load_start, park_start, parked, io_active;
  logic illum_select_0, illum_select_0_oe, illum_select_1;
  logic illum_select_1_oe, flash_serial_clock_oe, flash_serial_out_oe;
  logic flash_chip_select_oe, host_may_command, park_hold_done;
  logic park_start2, irq_wire;
  logic seen2 = 1'b0;
  logic was_io = 1'b0;
  logic was_irq = 1'b1;
  logic was_park = 1'b0;
  integer seed = 32'ha6e0f085;
  int mismatches = 0;
  int comparisons = 0;
  logic [15:0] notes[$];
  rifp_if link();
  rifp_if link2();
  always #12.5 clk = ~clk;
  assign irq_wire = link.host_irq_oe ? link.host_irq_o : 1'b1;
  rifp_supervisor #(.WARN_CYC(WCYC)) i_rifp_supervisor (.clk, .rstn,
    .link, .power_good, .power_failing, .host_may_command, .park_hold_done);
  rifp_controller #(.FILTER_CYC(FCYC)) i_rifp_controller (.clk, .rstn,
    .link, .pll_locked, .flash_load_done, .park_done, .test_in, .test_cfg,
    .test_oe, .flash_load_start, .park_start, .parked, .illum_select_0,
    .illum_select_0_oe, .illum_select_1, .illum_select_1_oe,
    .flash_serial_clock_oe, .flash_serial_out_oe, .flash_chip_select_oe,
    .io_active);
  // A second controller lets the bench shape its park input directly.
  rifp_controller #(.FILTER_CYC(FCYC)) i_rifp_controller_2 (.clk, .rstn,
    .link(link2), .pll_locked, .flash_load_done, .park_done, .test_in,
    .test_cfg(), .test_oe(), .flash_load_start(), .park_start(park_start2),
    .parked(), .illum_select_0(), .illum_select_0_oe(), .illum_select_1(),
    .illum_select_1_oe(), .flash_serial_clock_oe(), .flash_serial_out_oe(),
    .flash_chip_select_oe(), .io_active());
  rifp_asserts #(.WARN_CYC(WCYC)) i_rifp_asserts (.clk, .rstn,
    .sys_reset_low(link.sys_reset_low),
    .fast_park_request_n(link.fast_park_request_n),
    .host_irq_o(link.host_irq_o), .host_irq_oe(link.host_irq_oe));
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic await(ref logic s, input logic v);
    for (int n = 0; n < 200 && s !== v; n++) begin
      @(posedge clk);
      #1;
    end
    if (s !== v) begin
      mismatches++;
      wrap_up();
    end
  endtask
  task automatic take(input logic [15:0] got);
    check(got, (notes.size() == 0) ? 16'hdead : notes.pop_front());
  endtask
  function automatic logic [15:0] pins();
    return {6'h00, illum_select_0, illum_select_1, io_active,
      illum_select_0_oe, illum_select_1_oe, flash_serial_clock_oe,
      flash_serial_out_oe, flash_chip_select_oe, link.host_irq_oe, irq_wire};
  endfunction
  // Turns each output event of the first controller into a result and matches it to its note.
  always @(posedge clk) begin
    #1;
    if (io_active === 1'b1 && !was_io) take({8'h01, test_cfg});
    if (flash_load_start === 1'b1) take({8'h02, test_cfg});
    if (irq_wire === 1'b0 && was_irq) take({8'h03, test_oe});
    if (park_start === 1'b1) take({8'h04, 7'h00, parked});
    if (parked === 1'b1 && !was_park) take({8'h05, 7'h00, io_active});
    if (park_start2 === 1'b1) seen2 = 1'b1;
    was_io = io_active === 1'b1;
    was_irq = irq_wire !== 1'b0;
    was_park = parked === 1'b1;
  end
  initial begin
    logic [7:0] tv;
    link2.sys_reset_low <= 1'b0;
    link2.fast_park_request_n <= 1'b1;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      tv = (i == 0) ? (8'($random(seed)) | 8'h01) : TEST_DEFAULT;
      repeat (3) @(posedge clk);
      #1;
      check(pins(), 16'h0001);
      check({8'h00, test_oe}, 16'h0000);
      @(posedge clk);
      test_in <= tv;
      power_good <= 1'b1;
      link2.sys_reset_low <= 1'b1;
      notes.push_back({8'h01, tv});
      await(io_active, 1'b1);
      check(pins(), 16'h00ff);
      @(posedge clk);
      test_in <= ~tv;
      repeat (($random(seed) & 7) + 2) @(posedge clk);
      pll_locked <= 1'b1;
      notes.push_back({8'h02, tv});
      repeat (4) @(posedge clk);
      flash_load_done <= 1'b1;
      notes.push_back({8'h03, (tv != TEST_DEFAULT) ? 8'hff : 8'h00});
      await(host_may_command, 1'b1);
      check({15'h0000, irq_wire}, 16'h0000);
      if (i == 0) begin
        @(posedge clk);
        link2.fast_park_request_n <= 1'b0;
        repeat (FCYC) @(posedge clk);
        link2.fast_park_request_n <= 1'b1;
        repeat (12) @(posedge clk);
        check({15'h0000, seen2}, 16'h0000);
        link2.fast_park_request_n <= 1'b0;
        repeat (FCYC + 12) @(posedge clk);
        check({15'h0000, seen2}, 16'h0001);
      end
      @(posedge clk);
      power_failing <= 1'b1;
      notes.push_back(16'h0400);
      notes.push_back(16'h0501);
      await(park_start, 1'b1);
      @(posedge clk);
      park_done <= 1'b1;
      await(park_hold_done, 1'b1);
      repeat (4) @(posedge clk);
      power_failing <= 1'b0;
      power_good <= 1'b0;
      pll_locked <= 1'b0;
      flash_load_done <= 1'b0;
      park_done <= 1'b0;
    end
    repeat (6) @(posedge clk);
    #1;
    check(16'(notes.size()), 16'h0000);
    wrap_up();
  end
endmodule
